// ==== pll_divider_ref_select.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// (RQ1) primary bit chooses crystal or alternate input
// (RQ2) select pin low primary, high secondary
// (RQ3) select pin ignored in pin-control mode 2
// (RQ4) host programs switchover bits upper zero
// (RQ5) load cap is 3.5pF plus code eighths
// (RQ6) host keeps default load and drive with clock
// (RQ7) each PLL pre-scaler divides by 1..255
// (RQ8) pre-scaler zero powers down PLL and outputs
// (RQ9) ratio twice count plus adjust plus one
// (RQ10) adjust code zero counts as minus one
// (RQ11) host keeps adjust and count in range
// (RQ12) third PLL ratio is its count only
// (RQ13) zero count lets oscillator fall to minimum
// (RQ14) banks two-six post-divide, bank one none
// (RQ15) post mode: off, /1, /2, count+2
// (RQ16) disabled post-divider: no clock, still powered
// (RQ17) extra divide-by-two on banks two-six
// (RQ18) reprogramming dividers may glitch outputs
// (RQ19) mode pin picks serial, pin-control or scan
module pll_divider_ref_select (
   input  wire logic                                    i_clock,      // 200 MHz clock
   input  wire logic                                    i_rst,        // sync reset, high
   input  wire logic                                    i_reg_wr,     // register write strobe
   input  wire logic [7:0]                              i_reg_addr,   // register offset
   input  wire logic [7:0]                              i_reg_wdata,  // write data
   output var  logic [7:0]                              o_reg_rdata,  // read data, next cycle
   input  wire pll_divider_ref_select_pkg::ref_pins_t   i_ref_pins,   // reference and select pins
   input  wire pll_divider_ref_select_pkg::mode_level_t i_mode_level, // three-level mode pin
   input  wire logic [1:0]                              i_pin_frequency_control, // pin-control mode
   input  wire pll_divider_ref_select_pkg::cfg_t        i_cfg,        // divider settings
   input  wire logic [2:0]                              i_vco_tick,   // oscillator event per PLL
   output var  pll_divider_ref_select_pkg::prog_port_t  o_prog_port,  // active programming port
   output var  logic                                    o_ref_is_alt, // alternate input feeds PLLs
   output var  logic                                    o_ref_on_secondary, // secondary in use
   output var  logic                                    o_ref_tick,   // selected reference edge
   output var  logic [2:0]                              o_pfd_tick,   // pre-scaled reference
   output var  logic [2:0]                              o_pll_on,     // PLL powered
   output var  logic [2:0]                              o_vco_min,    // oscillator to minimum
   output var  logic [2:0][19:0]                        o_fb_ratio,   // ratio, 6 fraction bits
   output var  logic [8:0]                              o_load_eighths, // load cap in 0.125 pF
   output var  logic [1:0]                              o_crystal_drive_field, // oscillator drive
   output var  logic [5:0]                              o_bank_clk,   // bank clocks
   output var  logic [5:0]                              o_bank_pow    // bank powered
);
   import pll_divider_ref_select_pkg::*;

   main_state_t      st_ff;
   main_state_t      nxt_st;
   logic [5:0]       src_tick;
   logic [5:0]       post_tick;
   logic [5:0][10:0] post_div;
   logic [2:0]       pfd_tick;

   // ****************************************
   // dividers
   // ****************************************
   generate
      for (genvar p = 0; p < NUM_PLL; p++) begin : g_pre
         pulse_divider #(.W(8)) u_pre (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_tick  (st_ff.ref_tick),
            .i_div   (i_cfg.pre_div[p]),   // see RQ7
            .o_tick  (pfd_tick[p])
         );
      end
      for (genvar b = 0; b < NUM_BANK; b++) begin : g_post
         // unsupported source code 3 gives no clock
         assign src_tick[b] = (i_cfg.bank_source[b] != 2'h3) &&
                              i_vco_tick[i_cfg.bank_source[b]] && st_ff.pll_on[i_cfg.bank_source[b]];
         always_comb begin
            case (i_cfg.post_mode[b])  // see RQ15
               PM_OFF:  post_div[b] = 11'h000;
               PM_DIV1: post_div[b] = 11'h001;
               PM_DIV2: post_div[b] = 11'h002;
               default: post_div[b] = {1'b0, i_cfg.post_count[b]} + POST_OFFSET;
            endcase
         end
         // divisor applied immediately: a change mid-count may glitch, see RQ18
         pulse_divider #(.W(11)) u_post (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .i_tick  (src_tick[b]),
            .i_div   (post_div[b]),
            .o_tick  (post_tick[b])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic       sel_level;
      logic       pin_ok;
      logic [1:0] src;
      logic [13:0] whole;
      nxt_st    = st_ff;
      sel_level = 1'b0;
      pin_ok    = 1'b0;
      src       = 2'h0;
      whole     = 14'h0000;

      if (i_reg_wr) begin
         case (i_reg_addr)
            OFS_CRYSTAL_LOAD:  nxt_st.crystal_load_code = i_reg_wdata;
            OFS_CRYSTAL_DRIVE: nxt_st.crystal_drive_field = i_reg_wdata[DRIVE_LSB +: 2];
            OFS_REF_CTRL: begin
               nxt_st.primary_ref_choice    = i_reg_wdata[PRIMARY_BIT];
               nxt_st.switchover_mode_field = i_reg_wdata[SM_LSB +: 2];
            end
            default: ;
         endcase
      end
      case (i_reg_addr)
         OFS_CRYSTAL_LOAD:  nxt_st.rdata = st_ff.crystal_load_code;
         OFS_CRYSTAL_DRIVE: nxt_st.rdata = {6'h00, st_ff.crystal_drive_field};
         OFS_REF_CTRL:      nxt_st.rdata = {5'h00, st_ff.switchover_mode_field, st_ff.primary_ref_choice};
         default:           nxt_st.rdata = 8'h00;
      endcase
      nxt_st.load_eighths = LOAD_BASE_EIGHTHS + {1'b0, st_ff.crystal_load_code};  // see RQ5

      case (i_mode_level)  // see RQ19
         LVL_HIGH: nxt_st.prog = PROG_SERIAL;
         LVL_MID:  nxt_st.prog = PROG_PIN_FREQ;
         default:  nxt_st.prog = PROG_SCAN;
      endcase
      // pin shared with pin-control mode 2, and only manual switchover honours it
      pin_ok = !(i_mode_level == LVL_MID && i_pin_frequency_control == MFC_MODE2) &&  // see RQ3
               !st_ff.switchover_mode_field[1];
      nxt_st.on_secondary = pin_ok && i_ref_pins.general_input_five;              // see RQ2
      nxt_st.use_alt      = st_ff.primary_ref_choice ^ nxt_st.on_secondary;       // see RQ1
      sel_level = st_ff.use_alt ? i_ref_pins.alternate_clock_input : i_ref_pins.crystal_ref_input;
      nxt_st.ref_prev = sel_level;
      nxt_st.ref_tick = sel_level && !st_ff.ref_prev;

      for (int p = 0; p < NUM_PLL; p++) begin
         nxt_st.pll_on[p]  = (i_cfg.pre_div[p] != 8'h00);   // see RQ8
         nxt_st.vco_min[p] = (i_cfg.fb_count[p] == 12'h000); // see RQ13
      end
      for (int p = 0; p < 2; p++) begin
         // adjust 0 means -1, cancelling the +1
         whole = {1'b0, i_cfg.fb_count[p], 1'b0} +
                 ((i_cfg.fb_adjust[p] == 4'h0) ? 14'h0000 : {10'h000, i_cfg.fb_adjust[p]} + 14'h0001); // see RQ10
         nxt_st.ratio[p] = {whole, {FRAC_BITS{1'b0}}} +
                           (i_cfg.ss_enable[p] ? {14'h0000, i_cfg.ss_offset[p]} : 20'h00000); // see RQ9
      end
      nxt_st.ratio[2] = {2'h0, i_cfg.fb_count[2], {FRAC_BITS{1'b0}}};  // see RQ12

      for (int b = 0; b < NUM_BANK; b++) begin
         src = i_cfg.bank_source[b];
         nxt_st.bank_pow[b] = (src != 2'h3) && st_ff.pll_on[src];  // see RQ8
         if (!nxt_st.bank_pow[b]) begin
            nxt_st.bank_clk[b] = 1'b0;
         end else if (b == 0) begin
            nxt_st.bank_clk[b] = src_tick[b];  // see RQ14
         end else if (i_cfg.post_mode[b] == PM_OFF) begin
            nxt_st.bank_clk[b] = 1'b0;  // see RQ16
         end else if (post_tick[b]) begin
            nxt_st.bank_clk[b] = !st_ff.bank_clk[b];  // see RQ17
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_ff                       <= '0;
         st_ff.crystal_load_code     <= RST_LOAD_CODE;
         st_ff.crystal_drive_field   <= RST_DRIVE;
         st_ff.primary_ref_choice    <= RST_PRIMARY;
         st_ff.switchover_mode_field <= RST_SM;
         st_ff.load_eighths          <= LOAD_BASE_EIGHTHS;
         st_ff.prog                  <= PROG_SCAN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_reg_rdata           = st_ff.rdata;
   assign o_prog_port           = st_ff.prog;
   assign o_ref_is_alt          = st_ff.use_alt;
   assign o_ref_on_secondary    = st_ff.on_secondary;
   assign o_ref_tick            = st_ff.ref_tick;
   assign o_pfd_tick            = pfd_tick;
   assign o_pll_on              = st_ff.pll_on;
   assign o_vco_min             = st_ff.vco_min;
   assign o_fb_ratio            = st_ff.ratio;
   assign o_load_eighths        = st_ff.load_eighths;
   assign o_crystal_drive_field = st_ff.crystal_drive_field;
   assign o_bank_clk            = st_ff.bank_clk;
   assign o_bank_pow            = st_ff.bank_pow;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   load_cap_a: assert property (i_reg_wr && i_reg_addr == OFS_CRYSTAL_LOAD  // see RQ5
      |=> ##1 o_load_eighths == 9'h01C + {1'b0, $past(i_reg_wdata, 2)}) else $error("load cap wrong");
   primary_sel_a: assert property (##1 o_ref_is_alt ==  // see RQ1
      ($past(st_ff.primary_ref_choice) ^ o_ref_on_secondary)) else $error("primary choice wrong");
   pin_sel_a: assert property (i_mode_level == LVL_HIGH && !st_ff.switchover_mode_field[1]  // see RQ2
      |=> o_ref_on_secondary == $past(i_ref_pins.general_input_five)) else $error("select pin ignored");
   mfc_two_a: assert property (i_mode_level == LVL_MID && i_pin_frequency_control == MFC_MODE2  // see RQ3
      |=> !o_ref_on_secondary) else $error("select pin used in mode 2");
   pre_zero_a: assert property (i_cfg.pre_div[0] == 8'h00 && i_cfg.bank_source[1] == 2'h0  // see RQ8
      |=> !o_pll_on[0] ##1 !o_bank_pow[1] && !o_bank_clk[1]) else $error("pll not powered down");
   ratio_adj_a: assert property (!i_cfg.ss_enable[1] && i_cfg.fb_adjust[1] == 4'h0  // see RQ10
      |=> o_fb_ratio[1] == {1'b0, $past(i_cfg.fb_count[1]), 1'b0, 6'h00}) else $error("adjust zero wrong");
   ratio_ss_a: assert property (i_cfg.ss_enable[1] && i_cfg.fb_adjust[1] == 4'h1  // see RQ9
      |=> o_fb_ratio[1] == {1'b0, $past(i_cfg.fb_count[1]), 1'b0, 6'h00} + 20'h00080
          + $past(i_cfg.ss_offset[1])) else $error("ratio with offset wrong");
   ratio_two_a: assert property (1'b1  // see RQ12
      |=> o_fb_ratio[2] == {2'h0, $past(i_cfg.fb_count[2]), 6'h00}) else $error("third ratio wrong");
   vco_min_a: assert property (i_cfg.fb_count[1] == 12'h000 |=> o_vco_min[1]) else $error("vco min missed"); // see RQ13
   // bank power trails pll power by a cycle, so both must have settled
   post_off_a: assert property (i_cfg.post_mode[2] == PM_OFF && o_bank_pow[2] && $stable(i_cfg)  // see RQ16
      && $stable(o_pll_on)
      |=> !o_bank_clk[2] && o_bank_pow[2]) else $error("disabled bank shows clock or power lost");
   half_rate_a: assert property (o_bank_pow[3] && !post_tick[3] && i_cfg.post_mode[3] != PM_OFF  // see RQ17
      && $stable(i_cfg) && $stable(o_pll_on)
      |=> $stable(o_bank_clk[3])) else $error("bank toggled without post tick");

   cov_switch_c: cover property (!o_ref_on_secondary ##1 o_ref_on_secondary);
   cov_bank_clk_c: cover property (!o_bank_clk[4] ##1 o_bank_clk[4]);
   cov_pll_off_c: cover property (o_pll_on[2] ##1 !o_pll_on[2]);

endmodule
`default_nettype wire

// ==== pll_divider_ref_select_pkg.sv ====
`default_nettype none
package pll_divider_ref_select_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_PLL  = 3;
   localparam int NUM_BANK = 6;

   // ****************************************
   // register offsets, fields, reset values
   // ****************************************
   localparam logic [7:0] OFS_CRYSTAL_DRIVE = 8'h06;
   localparam logic [7:0] OFS_CRYSTAL_LOAD  = 8'h07;
   localparam logic [7:0] OFS_REF_CTRL      = 8'h34;
   localparam int         DRIVE_LSB         = 0;
   localparam int         PRIMARY_BIT       = 0;
   localparam int         SM_LSB            = 1;
   localparam logic [7:0] RST_LOAD_CODE     = 8'h00;
   localparam logic [1:0] RST_DRIVE         = 2'h3;
   localparam logic       RST_PRIMARY       = 1'h0;
   localparam logic [1:0] RST_SM            = 2'h0;

   // load capacitance in 0.125 pF steps: 3.5 pF base
   localparam logic [8:0] LOAD_BASE_EIGHTHS = 9'h01C;

   // ****************************************
   // encodings
   // ****************************************
   localparam logic [1:0]  PM_OFF      = 2'h0;
   localparam logic [1:0]  PM_DIV1     = 2'h1;
   localparam logic [1:0]  PM_DIV2     = 2'h2;
   localparam logic [10:0] POST_OFFSET = 11'h002;
   localparam logic [1:0]  MFC_MODE2   = 2'h2;
   localparam int          FRAC_BITS   = 6;

   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} mode_level_t;
   typedef enum logic [1:0] {PROG_SCAN, PROG_PIN_FREQ, PROG_SERIAL} prog_port_t;

   typedef struct packed {
      logic             crystal_ref_input;
      logic             alternate_clock_input;
      logic             general_input_five;
   } ref_pins_t;

   typedef struct packed {
      logic [2:0][7:0]  pre_div;
      logic [2:0][11:0] fb_count;
      logic [1:0][3:0]  fb_adjust;
      logic [1:0]       ss_enable;
      logic [1:0][5:0]  ss_offset;
      logic [5:0][1:0]  post_mode;
      logic [5:0][9:0]  post_count;
      logic [5:0][1:0]  bank_source;
   } cfg_t;

   typedef struct packed {
      logic [7:0]       crystal_load_code;
      logic [1:0]       crystal_drive_field;
      logic             primary_ref_choice;
      logic [1:0]       switchover_mode_field;
      logic [7:0]       rdata;
      logic [8:0]       load_eighths;
      logic             ref_prev;
      logic             ref_tick;
      logic             use_alt;
      logic             on_secondary;
      prog_port_t       prog;
      logic [2:0]       pll_on;
      logic [2:0]       vco_min;
      logic [2:0][19:0] ratio;
      logic [5:0]       bank_clk;
      logic [5:0]       bank_pow;
   } main_state_t;

endpackage
`default_nettype wire

// ==== pulse_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
   parameter int W = 8
) (
   input  wire logic         i_clock,  // system clock
   input  wire logic         i_rst,    // sync reset, high
   input  wire logic         i_tick,   // input event pulse
   input  wire logic [W-1:0] i_div,    // divisor, 0 stops output
   output var  logic         o_tick    // one pulse per i_div input pulses
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } div_state_t;

   div_state_t st_ff;
   div_state_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (i_div == '0) begin
         nxt_st.cnt = '0;
      end else if (i_tick) begin
         // >= so that lowering the divisor mid-count cannot hang
         if (st_ff.cnt >= i_div - W'(1)) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_tick = st_ff.tick;

   // ****************************************
   // checks
   // ****************************************
   div_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_div == '0) |=> !o_tick) else $error("divider ticked with zero divisor");
   div_one_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_div == W'(1) && i_tick) |=> o_tick) else $error("divide by one missed a pulse");

endmodule
`default_nettype wire

// ==== ref_clock_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// reference clock source: crystal and alternate input
// ****************************************
module ref_clock_source #(
   parameter int XTAL_HALF = 2,
   parameter int ALT_HALF  = 3
) (
   input  wire logic i_clock,   // bench clock
   input  wire logic i_rst,     // sync reset, high
   output var  logic o_crystal, // crystal or external reference level
   output var  logic o_alt      // alternate clock input level
);
   int xtal_cnt;
   int alt_cnt;

   // unequal rates so a wrong input choice shows in the edge count
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         xtal_cnt  <= 0;
         alt_cnt   <= 0;
         o_crystal <= 1'b0;
         o_alt     <= 1'b0;
      end else begin
         xtal_cnt <= (xtal_cnt == XTAL_HALF - 1) ? 0 : xtal_cnt + 1;
         alt_cnt  <= (alt_cnt == ALT_HALF - 1) ? 0 : alt_cnt + 1;
         if (xtal_cnt == XTAL_HALF - 1) o_crystal <= ~o_crystal;
         if (alt_cnt == ALT_HALF - 1) o_alt <= ~o_alt;
      end
   end
endmodule
`default_nettype wire

// ==== pll_divider_ref_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pll_divider_ref_select_tb;
   import pll_divider_ref_select_pkg::*;
   logic              i_clock, i_rst, reg_wr, sel_pin, xtal, alt, ref_alt, on_sec, ref_tick;
   logic [7:0]        reg_addr, reg_wdata, rdata;
   logic [1:0]        pfc, drive;
   logic [2:0]        vco, pfd, pll_on, vco_min;
   logic [2:0][19:0]  ratio;
   logic [8:0]        load;
   logic [5:0]        bank_clk, bank_pow;
   mode_level_t       mode_lvl;
   prog_port_t        prog;
   cfg_t              cfg;
   int                mismatches, checks, n_ref, n_pfd, n_b0, n_b1;
   int                exp_tog[4] = '{0, 60, 30, 20};

   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   ref_clock_source u_ref_clock_source (.i_clock(i_clock), .i_rst(i_rst), .o_crystal(xtal), .o_alt(alt));

   pll_divider_ref_select u_pll_divider_ref_select (
      .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .i_ref_pins({xtal, alt, sel_pin}),
      .i_mode_level(mode_lvl), .i_pin_frequency_control(pfc), .i_cfg(cfg), .i_vco_tick(vco),
      .o_prog_port(prog), .o_ref_is_alt(ref_alt), .o_ref_on_secondary(on_sec), .o_ref_tick(ref_tick),
      .o_pfd_tick(pfd), .o_pll_on(pll_on), .o_vco_min(vco_min), .o_fb_ratio(ratio),
      .o_load_eighths(load), .o_crystal_drive_field(drive), .o_bank_clk(bank_clk), .o_bank_pow(bank_pow));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic step(int n);
      repeat (n) begin
         @(posedge i_clock);
         #1;
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      step(1);
      reg_wr = 1'b0;
      // let an edge pass so back-to-back writes never retoggle the strobe at once
      step(1);
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      reg_addr = a;
      step(1);
      check("read data", 20'(rdata), 20'(exp));
   endtask

   // vco events every other cycle: 60 events in 120 cycles
   task automatic measure(int n);
      logic b1_prev;
      b1_prev = bank_clk[1];
      {n_ref, n_pfd, n_b0, n_b1} = '0;
      for (int i = 0; i < n; i++) begin
         vco = (i % 2 == 0) ? 3'h7 : 3'h0;
         step(1);
         n_ref += int'(ref_tick);
         n_pfd += int'(pfd[0]);
         n_b0 += int'(bank_clk[0]);
         n_b1 += int'(bank_clk[1] !== b1_prev);
         b1_prev = bank_clk[1];
      end
      vco = 3'h0;
   endtask

   function automatic logic [19:0] near(int seen, int exp);
      return 20'((seen >= exp - 1) && (seen <= exp + 1));
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_reset_regs();
      check("load eighths", 20'(load), 20'h0001C);
      check("drive field", 20'(drive), 20'h00003);
      rd(8'h07, 8'h00);
      rd(8'h06, 8'h03);
      wr(8'h07, 8'hFF);
      step(2);
      check("load eighths max", 20'(load), 20'h0011B);
      rd(8'h07, 8'hFF);
      wr(8'h07, 8'h00);
      wr(8'h55, 8'hA5);
      rd(8'h55, 8'h00);
      wr(8'h06, 8'h01);
      step(2);
      check("drive written", 20'(drive), 20'h00001);
      wr(8'h06, 8'h03);
      for (int i = 0; i < 3; i++) begin
         mode_lvl = mode_level_t'(i);
         step(2);
         check("prog port", 20'(prog), 20'(i));
      end
      $display("test_reset_regs done");
   endtask

   task automatic test_ref_select();
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 2; s++) begin
            wr(8'h34, 8'(p));
            sel_pin = s[0];
            step(2);
            check("on secondary", 20'(on_sec), 20'(s));
            check("alt selected", 20'(ref_alt), 20'(p ^ s));
            measure(120);
            check("ref edges", near(n_ref, ((p ^ s) != 0) ? 20 : 30), 20'h1);
         end
      end
      wr(8'h34, 8'h00);
      mode_lvl = LVL_MID;
      pfc = 2'h2;
      step(2);
      check("pin in mode 2", 20'(on_sec), 20'h0);
      pfc = 2'h1;
      step(2);
      check("pin in mode 1", 20'(on_sec), 20'h1);
      mode_lvl = LVL_HIGH;
      wr(8'h34, 8'h04);
      step(2);
      check("auto bits", 20'(on_sec), 20'h0);
      wr(8'h34, 8'h02);
      step(2);
      check("manual bits 01", 20'(on_sec), 20'h1);
      wr(8'h34, 8'h00);
      sel_pin = 1'b0;
      $display("test_ref_select done");
   endtask

   task automatic test_dividers();
      cfg.pre_div[0] = 8'h03;
      cfg.fb_count = {12'hFFF, 12'h016, 12'h016};
      cfg.fb_adjust = {4'h0, 4'h3};
      step(2);
      check("pll on", 20'(pll_on), 20'h7);
      check("ratio 0", ratio[0], 20'h00C00);
      check("ratio adj 0", ratio[1], 20'h00B00);
      check("ratio 2", ratio[2], 20'h3FFC0);
      cfg.fb_count[1] = 12'h011;
      cfg.fb_adjust[1] = 4'h1;
      cfg.ss_enable[1] = 1'b1;
      cfg.ss_offset[1] = 6'h30;
      cfg.fb_count[0] = 12'h000;
      step(2);
      check("ratio frac", ratio[1], 20'h00930);
      check("vco min", 20'(vco_min), 20'h1);
      cfg.fb_count[0] = 12'h016;
      measure(120);
      check("pfd ticks", near(n_pfd, 10), 20'h1);
      check("bank one copy", near(n_b0, 60), 20'h1);
      for (int m = 0; m < 4; m++) begin
         cfg.post_mode[1] = 2'(m);
         step(4);
         measure(120);
         check("bank two toggles", near(n_b1, exp_tog[m]), 20'h1);
         check("bank two powered", 20'(bank_pow[1]), 20'h1);
      end
      cfg.pre_div[0] = 8'h00;
      step(3);
      check("pll off", 20'(pll_on), 20'h6);
      check("banks off", 20'(bank_pow), 20'h0);
      $display("test_dividers done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clock);
      mismatches++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      {reg_wr, sel_pin, reg_addr, reg_wdata, pfc, vco} = '0;
      i_rst = 1'b1;
      mode_lvl = LVL_LOW;
      cfg = '0;
      cfg.pre_div = {8'h01, 8'h01, 8'h01};
      // banks 0..4 on pll0, bank 5 unrouted; banks 2..4 keep the checks busy
      cfg.bank_source = {2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
      cfg.post_count[1] = 10'h001;
      cfg.post_mode[3] = 2'h1;
      cfg.post_mode[4] = 2'h2;
      step(12);
      i_rst = 1'b0;
      test_reset_regs();
      test_ref_select();
      test_dividers();
      wrap_up();
   end
endmodule
`default_nettype wire
